// ===== include/vpw_link_pkg.sv
// Package: constants, types and register map of the VPW link port
`default_nettype none

package vpw_link_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS   = 10;
	localparam int BIT_NS   = 96000;
	localparam int HALF_CYC = (BIT_NS / 2) / CLK_NS;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] OFF_VECTOR = 5'h00;
	localparam logic [4:0] OFF_DATA   = 5'h04;
	localparam logic [4:0] OFF_CTL1   = 5'h08;
	localparam logic [4:0] OFF_CTL2   = 5'h0c;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_MASK   = 5'h14;

	// ------------------------------------------------------------
	// Source bits (vector code is index plus one)
	// ------------------------------------------------------------
	localparam int NUM_SRC   = 8;
	localparam int SRC_EOF   = 0;
	localparam int SRC_RESPONSE_BYTE_RECEIVED = 1;
	localparam int SRC_RX_FULL_FLAG  = 2;
	localparam int SRC_TX_EMPTY_FLAG  = 3;
	localparam int SRC_LOA   = 4;
	localparam int SRC_CRC   = 5;
	localparam int SRC_SYM   = 6;
	localparam int SRC_WAKE  = 7;
	localparam logic [3:0] CODE_RESPONSE_BYTE_RECEIVED = 4'h2;
	localparam logic [3:0] CODE_RX_FULL_FLAG  = 4'h3;
	localparam logic [3:0] CODE_TX_EMPTY_FLAG  = 4'h4;

	// ------------------------------------------------------------
	// Control fields, reset values, CRC
	// ------------------------------------------------------------
	localparam int C1_IRQ_EN = 0;
	localparam int C1_SLEEP  = 1;
	localparam int C2_LOOP   = 0;
	localparam int C2_SEND_END_OF_DATA   = 1;
	localparam int C2_IFR    = 2;
	localparam logic [7:0] MASK_RST = 8'hff;
	localparam logic [7:0] CRC_INIT = 8'hff;
	localparam logic [7:0] CRC_POLY = 8'h1d;
	localparam logic [7:0] CRC_GOOD = 8'hc4;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SOF  = 2'b01,
		TX_DATA = 2'b11,
		TX_TAIL = 2'b10
	} tx_state_t;

	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} avmm_req_t;

	typedef struct packed {
		logic [31:0] readdata;
		logic        waitrequest;
	} avmm_rsp_t;

	typedef struct packed {
		logic        wait_r;
		logic [31:0] rdata;
		logic [3:0]  code;
		logic [2:0]  armed;
		logic [7:0]  status;
		logic [7:0]  mask;
		logic [1:0]  ctl1;
		logic [2:0]  ctl2;
		logic        irq;
		tx_state_t   tx_st;
		logic [7:0]  tx_shadow;
		logic        tx_full;
		logic [7:0]  tx_shift;
		logic [3:0]  tx_nb;
		logic        tx_hf;
		logic [15:0] tx_cnt;
		logic        tx_line;
		logic [7:0]  tx_crc;
		logic        tx_last;
		logic        tx_fresh;
		logic        rx_act;
		logic        rx_sof;
		logic        rx_prev;
		logic        rx_hf;
		logic        rx_h0;
		logic [15:0] rx_cnt;
		logic [3:0]  rx_nb;
		logic [7:0]  rx_shift;
		logic [7:0]  rx_crc;
		logic [7:0]  rx_shadow;
	} state_t;

	localparam state_t STATE_RST = '{wait_r: 1'b1, mask: MASK_RST, tx_st: TX_IDLE,
		tx_line: 1'b1, rx_prev: 1'b1, tx_crc: CRC_INIT, rx_crc: CRC_INIT, default: '0};

	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] d);
		logic [7:0] c;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

endpackage

`default_nettype wire

// ===== logic/vpw_link.sv
// Vector register, data buffer and bit engine of the VPW link port
//
// What this block does
// - Vector register shows pending source code times four, zero to 0x20.
// - Highest pending source wins: wakeup, symbol, CRC, arbitration, tx, rx, response, EOF.
// - Vector read clears reported source, except data-buffer conditions.
// - Rx-full and response-byte clear on vector read then data read.
// - Tx-empty clears on vector read then data write, or end-of-data request.
// - Once a source clears the vector shows the next pending one.
// - Data read returns last received byte; read after rx-full.
// - Finished shift register takes the byte from the tx shadow.
// - Tx-empty rises once the first bit of a loaded byte left.
// - Completed rx byte moves to rx shadow and sets rx-full, or response-byte when IFR is set.
// - Next received byte overwrites the rx shadow; software reads in time.
// - Missing tx byte aborts frame mid-byte after two extra one-bits.
// - Receiver reports an aborted frame as invalid symbol.
// - Handler frames, arbitrates, checks CRC and detects errors.
// - Interrupt asserts only while the interrupt enable bit is set.
// - Loopback select feeds the receiver from tx line or rx line.
`timescale 1ns/10ps
`default_nettype none

module vpw_link
	import vpw_link_pkg::*;
#(
	parameter int HALF_CYCLES = HALF_CYC
) (
	// Clock, reset, enable
	input  wire logic      ref_clk,
	input  wire logic      rst_n,
	input  wire logic      clk_en,
	// Register bus
	input  wire avmm_req_t bus_req,
	output var avmm_rsp_t  bus_rsp,
	// Link lines
	input  wire logic      phy_rx_line,
	output var logic       phy_tx_line,
	// Interrupt
	output var logic       irq
);

	localparam logic [15:0] HALF_M1  = 16'(HALF_CYCLES - 1);
	localparam logic [15:0] HALF_MID = 16'(HALF_CYCLES / 2);

	state_t      s_r;
	state_t      s_nxt;
	logic        acc;
	logic        rxd;
	logic        load_next;
	logic        rx_byte_done;
	logic [7:0]  pend;
	logic [7:0]  set_ev;
	logic [7:0]  clr_ev;
	logic [3:0]  top_code;
	logic [31:0] rd_mux;

	assign bus_rsp.readdata    = s_r.rdata;
	assign bus_rsp.waitrequest = s_r.wait_r;
	assign phy_tx_line         = s_r.tx_line;
	assign irq                 = s_r.irq;

	// ------------------------------------------------------------
	// Source priority
	// ------------------------------------------------------------
	assign pend = s_r.status & s_r.mask;

	always_comb begin
		top_code = 4'h0;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pend[i]) begin
				top_code = 4'(i + 1);
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	always_comb begin
		case (bus_req.address)
			OFF_VECTOR: rd_mux = {26'h0, top_code, 2'b00};
			OFF_DATA:   rd_mux = {24'h0, s_r.rx_shadow};
			OFF_CTL1:   rd_mux = {30'h0, s_r.ctl1};
			OFF_CTL2:   rd_mux = {29'h0, s_r.ctl2};
			OFF_STATUS: rd_mux = {24'h0, s_r.status};
			OFF_MASK:   rd_mux = {24'h0, s_r.mask};
			default:    rd_mux = 32'h0;
		endcase
	end

	assign rxd = s_r.ctl2[C2_LOOP] ? s_r.tx_line : phy_rx_line;
	assign acc = (bus_req.read | bus_req.write) & ~s_r.wait_r & clk_en;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt        = s_r;
		set_ev       = 8'h0;
		clr_ev       = 8'h0;
		load_next    = 1'b0;
		rx_byte_done = 1'b0;

		// Transmitter
		if (s_r.tx_st != TX_IDLE) begin
			s_nxt.tx_cnt = s_r.tx_cnt - 16'h1;
		end
		case (s_r.tx_st)
			TX_IDLE: begin
				s_nxt.tx_line = 1'b1;
				if (s_r.tx_full && !s_r.rx_act && rxd) begin
					s_nxt.tx_st   = TX_SOF;
					s_nxt.tx_line = 1'b0;
					s_nxt.tx_cnt  = HALF_M1;
					s_nxt.tx_hf   = 1'b0;
					s_nxt.tx_crc  = CRC_INIT;
					s_nxt.tx_last = 1'b0;
				end
			end
			TX_SOF: begin
				if (s_r.tx_cnt == 16'h0) begin
					s_nxt.tx_cnt = HALF_M1;
					s_nxt.tx_hf  = 1'b1;
					load_next    = s_r.tx_hf;
				end
			end
			TX_DATA, TX_TAIL: begin
				if (s_r.tx_cnt == 16'h0) begin
					s_nxt.tx_cnt = HALF_M1;
					if (!s_r.tx_hf) begin
						s_nxt.tx_hf   = 1'b1;
						s_nxt.tx_line = ~s_r.tx_shift[7];
					end else begin
						s_nxt.tx_hf    = 1'b0;
						s_nxt.tx_shift = {s_r.tx_shift[6:0], 1'b0};
						s_nxt.tx_nb    = s_r.tx_nb - 4'h1;
						s_nxt.tx_line  = s_r.tx_shift[6];
						// first bit of a fresh byte is out
						if (s_r.tx_fresh) begin
							s_nxt.tx_fresh   = 1'b0;
							set_ev[SRC_TX_EMPTY_FLAG] = 1'b1;
						end
						if (s_r.tx_nb == 4'h1) begin
							if (s_r.tx_st == TX_TAIL) begin
								s_nxt.tx_st   = TX_IDLE;
								s_nxt.tx_line = 1'b1;
							end else begin
								load_next = 1'b1;
							end
						end
					end
				end
			end
			default: begin
				s_nxt.tx_st   = TX_IDLE;
				s_nxt.tx_line = 1'b1;
			end
		endcase

		if (load_next) begin
			s_nxt.tx_st  = TX_DATA;
			s_nxt.tx_nb  = 4'h8;
			s_nxt.tx_hf  = 1'b0;
			s_nxt.tx_cnt = HALF_M1;
			if (s_r.tx_full) begin
				s_nxt.tx_shift = s_r.tx_shadow;
				s_nxt.tx_full  = 1'b0;
				s_nxt.tx_fresh = 1'b1;
				s_nxt.tx_crc   = crc8_step(s_r.tx_crc, s_r.tx_shadow);
			end else if (s_r.ctl2[C2_SEND_END_OF_DATA] && !s_r.tx_last) begin
				s_nxt.tx_shift      = ~s_r.tx_crc;
				s_nxt.tx_last       = 1'b1;
				s_nxt.ctl2[C2_SEND_END_OF_DATA] = 1'b0;
			end else if (s_r.tx_last) begin
				s_nxt.tx_st = TX_IDLE;
			end else begin
				// underrun, two one-bits then release mid-byte
				s_nxt.tx_st    = TX_TAIL;
				s_nxt.tx_shift = 8'hff;
				s_nxt.tx_nb    = 4'h2;
			end
			s_nxt.tx_line = (s_nxt.tx_st == TX_IDLE) | s_nxt.tx_shift[7];
		end

		// arbitration, passive driven but dominant seen
		if ((s_r.tx_st == TX_SOF || s_r.tx_st == TX_DATA) && s_r.tx_cnt == HALF_MID
			&& s_r.tx_line && !rxd) begin
			s_nxt.tx_st     = TX_IDLE;
			s_nxt.tx_line   = 1'b1;
			s_nxt.tx_fresh  = 1'b0;
			set_ev[SRC_LOA] = 1'b1;
		end

		// Receiver
		s_nxt.rx_prev = rxd;
		if (!s_r.rx_act) begin
			if (s_r.rx_prev && !rxd) begin
				s_nxt.rx_act = 1'b1;
				s_nxt.rx_sof = 1'b1;
				s_nxt.rx_hf  = 1'b0;
				s_nxt.rx_cnt = HALF_MID;
				s_nxt.rx_nb  = 4'h0;
				s_nxt.rx_crc = CRC_INIT;
			end
		end else if (s_r.rx_cnt != 16'h0) begin
			s_nxt.rx_cnt = s_r.rx_cnt - 16'h1;
		end else if (!s_r.rx_hf) begin
			s_nxt.rx_cnt = HALF_M1;
			s_nxt.rx_hf  = 1'b1;
			s_nxt.rx_h0  = rxd;
		end else begin
			s_nxt.rx_cnt = HALF_M1;
			s_nxt.rx_hf  = 1'b0;
			if (s_r.rx_h0 != rxd && !s_r.rx_sof) begin
				s_nxt.rx_shift = {s_r.rx_shift[6:0], s_r.rx_h0};
				s_nxt.rx_nb    = s_r.rx_nb + 4'h1;
				if (s_r.rx_nb == 4'h7) begin
					rx_byte_done    = 1'b1;
					s_nxt.rx_nb     = 4'h0;
					s_nxt.rx_shadow = s_nxt.rx_shift;
					s_nxt.rx_crc    = crc8_step(s_r.rx_crc, s_nxt.rx_shift);
					if (s_r.ctl2[C2_IFR]) begin
						set_ev[SRC_RESPONSE_BYTE_RECEIVED] = 1'b1;
					end else begin
						set_ev[SRC_RX_FULL_FLAG] = 1'b1;
					end
				end
			end else if (!s_r.rx_h0 && !rxd && s_r.rx_sof) begin
				s_nxt.rx_sof     = 1'b0;
				set_ev[SRC_WAKE] = s_r.ctl1[C1_SLEEP];
			end else if (s_r.rx_h0 && rxd && !s_r.rx_sof && s_r.rx_nb == 4'h0) begin
				s_nxt.rx_act = 1'b0;
				if (s_r.rx_crc == CRC_GOOD) begin
					set_ev[SRC_EOF] = 1'b1;
				end else begin
					set_ev[SRC_CRC] = 1'b1;
				end
			end else begin
				s_nxt.rx_act    = 1'b0;
				set_ev[SRC_SYM] = 1'b1;
			end
		end

		// Register bus
		s_nxt.wait_r = ~((bus_req.read | bus_req.write) & s_r.wait_r);
		if (bus_req.read && s_r.wait_r) begin
			s_nxt.rdata = rd_mux;
			s_nxt.code  = top_code;
		end
		if (acc && bus_req.read && bus_req.address == OFF_VECTOR) begin
			case (s_r.code)
				4'h0:       s_nxt.armed = s_r.armed;
				CODE_RESPONSE_BYTE_RECEIVED: s_nxt.armed[0] = 1'b1;
				CODE_RX_FULL_FLAG:  s_nxt.armed[1] = 1'b1;
				CODE_TX_EMPTY_FLAG:  s_nxt.armed[2] = 1'b1;
				default:    clr_ev[3'(s_r.code - 4'h1)] = 1'b1;
			endcase
		end
		if (acc && bus_req.read && bus_req.address == OFF_DATA) begin
			clr_ev[SRC_RX_FULL_FLAG]  = s_r.armed[1];
			clr_ev[SRC_RESPONSE_BYTE_RECEIVED] = s_r.armed[0];
			s_nxt.armed[1:0]  = 2'b00;
		end
		if (acc && bus_req.write && bus_req.byteenable[0]) begin
			case (bus_req.address)
				OFF_DATA: begin
					s_nxt.tx_shadow = bus_req.writedata[7:0];
					s_nxt.tx_full   = 1'b1;
					clr_ev[SRC_TX_EMPTY_FLAG] = s_r.armed[2];
					s_nxt.armed[2]   = 1'b0;
				end
				OFF_CTL1: s_nxt.ctl1 = bus_req.writedata[1:0];
				OFF_CTL2: begin
					s_nxt.ctl2 = bus_req.writedata[2:0] | {1'b0, s_nxt.ctl2[C2_SEND_END_OF_DATA], 1'b0};
					if (bus_req.writedata[C2_SEND_END_OF_DATA]) begin
						clr_ev[SRC_TX_EMPTY_FLAG] = 1'b1;
						s_nxt.armed[2]   = 1'b0;
					end
				end
				OFF_STATUS: begin
					clr_ev = clr_ev | bus_req.writedata[7:0];
					// a source cleared by software drops its pending arm
					s_nxt.armed = s_r.armed & ~{bus_req.writedata[SRC_TX_EMPTY_FLAG],
						bus_req.writedata[SRC_RX_FULL_FLAG], bus_req.writedata[SRC_RESPONSE_BYTE_RECEIVED]};
				end
				OFF_MASK:   s_nxt.mask = bus_req.writedata[7:0];
				default:    s_nxt.mask = s_r.mask;
			endcase
		end

		// sources kept independently, set wins over clear
		s_nxt.status = (s_r.status & ~clr_ev) | set_ev;
		s_nxt.irq = s_nxt.ctl1[C1_IRQ_EN] & |(s_nxt.status & s_nxt.mask);
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s_r <= STATE_RST;
		end else if (clk_en) begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	sequence vec_capture;
		clk_en && bus_req.read && s_r.wait_r && bus_req.address == OFF_VECTOR;
	endsequence
	sequence vec_acc(logic [3:0] c);
		acc && bus_req.read && bus_req.address == OFF_VECTOR && s_r.code == c;
	endsequence
	sequence data_rd_acc;
		acc && bus_req.read && bus_req.address == OFF_DATA;
	endsequence

	AST_VEC_FIELD: assert property (vec_capture |=>
		s_r.rdata[31:6] == 26'h0 && s_r.rdata[1:0] == 2'b00)
		else $error("vector bits outside code field not zero");
	AST_VEC_WAKE: assert property (vec_capture and (pend[SRC_WAKE]) |=>
		s_r.rdata == 32'h20)
		else $error("wakeup not reported as 0x20");
	AST_VEC_PRIO: assert property (vec_capture and (pend[SRC_CRC] && !pend[SRC_SYM]
		&& !pend[SRC_WAKE]) |=> s_r.rdata == 32'h18)
		else $error("crc error not top source");
	AST_RD_CLEAR: assert property (vec_acc(4'h6) |=>
		!s_r.status[SRC_CRC] || $past(set_ev[SRC_CRC]))
		else $error("vector read left crc source set");
	AST_RX_FULL_FLAG_KEEP: assert property (vec_acc(CODE_RX_FULL_FLAG) |=> s_r.status[SRC_RX_FULL_FLAG])
		else $error("vector read cleared rx full");
	AST_RX_FULL_FLAG_CLR: assert property (vec_acc(CODE_RX_FULL_FLAG) ##[1:40] data_rd_acc |=>
		!s_r.status[SRC_RX_FULL_FLAG] || $past(set_ev[SRC_RX_FULL_FLAG]))
		else $error("rx full not cleared by data read");
	AST_SEND_END_OF_DATA_CLR: assert property (acc && bus_req.write && bus_req.byteenable[0]
		&& bus_req.address == OFF_CTL2 && bus_req.writedata[C2_SEND_END_OF_DATA]
		|=> !s_r.status[SRC_TX_EMPTY_FLAG] || $past(set_ev[SRC_TX_EMPTY_FLAG]))
		else $error("end-of-data request left tx empty");
	AST_TX_EMPTY_FLAG_BIT: assert property ($rose(s_r.status[SRC_TX_EMPTY_FLAG]) |->
		s_r.tx_st == TX_DATA && s_r.tx_nb == 4'h7 && !s_r.tx_hf)
		else $error("tx empty not after first bit");
	AST_UNDERRUN: assert property (clk_en && load_next && !s_r.tx_full
		&& !s_r.ctl2[C2_SEND_END_OF_DATA] && !s_r.tx_last
		|=> s_r.tx_st == TX_TAIL && s_r.tx_nb == 4'h2 && s_r.tx_line)
		else $error("underrun tail not started");
	AST_RX_FULL: assert property (clk_en && rx_byte_done && !s_r.ctl2[C2_IFR] |=>
		s_r.status[SRC_RX_FULL_FLAG] && s_r.rx_shadow == $past(s_nxt.rx_shadow))
		else $error("received byte not moved to shadow");
	AST_IRQ_EN: assert property (!s_r.ctl1[C1_IRQ_EN] |-> !irq)
		else $error("interrupt while disabled");
	AST_RESET: assert property ($rose(rst_n) |->
		s_r.status == 8'h0 && !irq && top_code == 4'h0)
		else $error("state pending after reset");

endmodule

`default_nettype wire

// ===== testbench/link_node.sv
// Other node on the link: sends short frames on the shared line
`timescale 1ns/10ps
`default_nettype none

module link_node #(
	parameter int HALF = 10
) (
	// Clock
	input  wire logic        ref_clk,
	// Frame request
	input  wire logic        go,
	input  wire logic [2:0]  nbytes,
	input  wire logic [31:0] bytes,
	input  wire logic        cut,
	// Line
	output var logic         line,
	output var logic         busy
);
	logic [31:0] sh;

	task automatic half(input logic v);
		line <= v;
		repeat (HALF) @(posedge ref_clk);
	endtask

	initial begin
		line = 1'b1;
		busy = 1'b0;
		forever begin
			@(posedge ref_clk);
			if (go) begin
				busy <= 1'b1;
				sh = bytes;
				half(1'b0);
				half(1'b0);
				for (int i = 0; i < 8 * nbytes; i++) begin
					half(sh[31]);
					half(~sh[31]);
					sh = sh << 1;
				end
				if (cut) begin
					half(1'b1);
					half(1'b0);
					half(1'b1);
					half(1'b0);
				end
				line <= 1'b1;
				repeat (10 * HALF) @(posedge ref_clk);
				busy <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// ===== testbench/testbench.sv
// Testbench of the VPW link port: registers, frames, loopback, interrupt
`timescale 1ns/10ps
`default_nettype none

module testbench
	import vpw_link_pkg::*;
();
	typedef struct packed {
		logic        chk;
		logic [31:0] val;
	} note_t;

	logic        ref_clk;
	logic        rst_n;
	logic        clk_en;
	avmm_req_t   req;
	avmm_rsp_t   rsp;
	logic        tx_line;
	logic        node_line;
	wire logic   rx_line;
	logic        irq;
	logic        go;
	logic        cut;
	logic [2:0]  nbytes;
	logic [31:0] bytes;
	logic        busy;
	logic [15:0] seed;
	logic [31:0] q;
	logic [7:0]  b1;
	logic [7:0]  t1;
	logic [7:0]  t2;
	logic [7:0]  cr;
	note_t       cur;
	note_t       notes[$];
	int          n_fail;
	int          tests_run;

	// Wired-AND line with pull-up
	assign rx_line = node_line & tx_line;

	vpw_link #(.HALF_CYCLES(10)) DUT (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.bus_req(req), .bus_rsp(rsp), .phy_rx_line(rx_line), .phy_tx_line(tx_line), .irq(irq));

	link_node #(.HALF(10)) node (.ref_clk(ref_clk), .go(go), .nbytes(nbytes), .bytes(bytes),
		.cut(cut), .line(node_line), .busy(busy));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("Checks %0d, errors %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic bus(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		req <= '{read: ~wr_en, write: wr_en, address: a, byteenable: 4'h1, writedata: d};
		do begin
			@(posedge ref_clk);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 50);
		if (rsp.waitrequest !== 1'b0)
			check(32'h1, 32'h0);
		q = rsp.readdata;
		req <= '0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		notes.push_back('{1'b1, exp});
		bus(1'b0, a, 32'h0);
	endtask

	task automatic peek(input logic [4:0] a);
		notes.push_back('{1'b0, 32'h0});
		bus(1'b0, a, 32'h0);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic wait_bits(input logic [4:0] a, input logic [31:0] m);
		int n;
		n = 0;
		do begin
			peek(a);
			n++;
		end while ((q & m) == 32'h0 && n < 1000);
		check(q & m, m);
	endtask

	task automatic irq_is(input logic v);
		repeat (3) @(posedge ref_clk);
		check({31'h0, irq}, {31'h0, v});
	endtask

	task automatic send(input logic [2:0] n, input logic [31:0] d, input logic c);
		int k;
		nbytes <= n;
		bytes <= d;
		cut <= c;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		repeat (2) @(posedge ref_clk);
		k = 0;
		while (busy && k < 5000) begin
			@(posedge ref_clk);
			k++;
		end
		check({31'h0, busy}, 32'h0);
	endtask

	// ------------------------------------------------------------
	// Read result monitor
	// ------------------------------------------------------------
	always @(posedge ref_clk) begin
		if (req.read && rsp.waitrequest === 1'b0 && notes.size() > 0) begin
			cur = notes.pop_front();
			if (cur.chk)
				check(rsp.readdata, cur.val);
		end
	end

	// ------------------------------------------------------------
	// Clock, watchdog, sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (30000) @(posedge ref_clk);
		n_fail++;
		test_done();
	end

	initial begin
		rst_n = 1'b0;
		clk_en = 1'b1;
		req = '0;
		go = 1'b0;
		cut = 1'b0;
		nbytes = 3'h0;
		bytes = 32'h0;
		n_fail = 0;
		tests_run = 0;
		seed = lfsr(16'hc7a0);
		b1 = seed[7:0];
		seed = lfsr(seed);
		t1 = seed[7:0];
		seed = lfsr(seed);
		t2 = seed[15:8];
		cr = ~crc8(8'hff, b1);
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(OFF_VECTOR, 32'h0);
		rd(OFF_MASK, {24'h0, MASK_RST});
		rd(5'h18, 32'h0);
		irq_is(1'b0);
		wr(OFF_CTL1, 32'h1);
		send(3'h2, {b1, cr, 16'h0}, 1'b0);
		rd(OFF_VECTOR, 32'h0c);
		irq_is(1'b1);
		rd(OFF_VECTOR, 32'h0c);
		rd(OFF_DATA, {24'h0, cr});
		rd(OFF_VECTOR, 32'h04);
		rd(OFF_VECTOR, 32'h0);
		irq_is(1'b0);
		send(3'h2, {b1, cr ^ 8'h01, 16'h0}, 1'b0);
		rd(OFF_VECTOR, 32'h18);
		rd(OFF_VECTOR, 32'h0c);
		wr(OFF_STATUS, 32'hff);
		send(3'h1, {b1, 24'h0}, 1'b1);
		rd(OFF_VECTOR, 32'h1c);
		rd(OFF_VECTOR, 32'h0c);
		irq_is(1'b1);
		wr(OFF_MASK, 32'h0);
		rd(OFF_VECTOR, 32'h0);
		irq_is(1'b0);
		wr(OFF_MASK, 32'hff);
		wr(OFF_CTL1, 32'h0);
		irq_is(1'b0);
		wr(OFF_STATUS, 32'hff);
		wr(OFF_CTL1, 32'h2);
		send(3'h1, {b1, 24'h0}, 1'b0);
		rd(OFF_VECTOR, 32'h20);
		wr(OFF_CTL1, 32'h0);
		wr(OFF_STATUS, 32'hff);
		// Arbitration loss against the other node, received bytes flagged as response
		wr(OFF_CTL2, 32'h4);
		wr(OFF_DATA, {24'h0, t1 | 8'h80});
		send(3'h2, {b1 & 8'h7f, ~crc8(8'hff, b1 & 8'h7f), 16'h0}, 1'b0);
		rd(OFF_VECTOR, 32'h14);
		rd(OFF_VECTOR, 32'h08);
		rd(OFF_DATA, {24'h0, ~crc8(8'hff, b1 & 8'h7f)});
		rd(OFF_VECTOR, 32'h04);
		wr(OFF_STATUS, 32'hff);
		wr(OFF_CTL2, 32'h1);
		wr(OFF_DATA, {24'h0, t1});
		wait_bits(OFF_STATUS, 32'h08);
		rd(OFF_VECTOR, 32'h10);
		wr(OFF_DATA, {24'h0, t2});
		rd(OFF_VECTOR, 32'h0);
		wr(OFF_CTL2, 32'h3);
		// Clock enable low freezes the transmitter mid-byte
		clk_en <= 1'b0;
		repeat (2) @(posedge ref_clk);
		cr = {7'h0, tx_line};
		for (int i = 0; i < 25; i++) begin
			@(posedge ref_clk);
			check({31'h0, tx_line}, {31'h0, cr[0]});
		end
		clk_en <= 1'b1;
		wait_bits(OFF_STATUS, 32'h01);
		rd(OFF_DATA, {24'h0, ~crc8(crc8(8'hff, t1), t2)});
		wr(OFF_STATUS, 32'hff);
		wr(OFF_DATA, {24'h0, t2});
		wait_bits(OFF_STATUS, 32'h40);
		rd(OFF_VECTOR, 32'h1c);
		wr(OFF_STATUS, 32'hff);
		rd(OFF_VECTOR, 32'h0);
		test_done();
	end
endmodule

`default_nettype wire
